// >>> rtl/prcg_bus_gate.sv
// Blocks peripheral register strobes while that peripheral's clock is stopped
`timescale 1ns/1ps
module prcg_bus_gate
  import prcg_pkg::*;
(
  // Clock gate state, one bit per gated peripheral
  input wire logic [prcg_pkg::PRCG_N_CLK-1:0] clk_dis,
  // Strobes from the processor bus decoder
  input wire logic [prcg_pkg::PRCG_N_CLK-1:0] wr_in,
  input wire logic [prcg_pkg::PRCG_N_CLK-1:0] rd_in,
  // Strobes passed on to the peripherals
  output logic [prcg_pkg::PRCG_N_CLK-1:0] wr_out,
  output logic [prcg_pkg::PRCG_N_CLK-1:0] rd_out,
  // Access refused this cycle
  output logic [prcg_pkg::PRCG_N_CLK-1:0] refused
);
  import prcg_pkg::*;

  wire [PRCG_N_CLK-1:0] open_w = ~clk_dis;

  // Combinational so the gate adds no cycle to peripheral accesses
  assign wr_out = wr_in & open_w;
  assign rd_out = rd_in & open_w;
  assign refused = (wr_in | rd_in) & clk_dis;

endmodule

// >>> rtl/prcg_pkg.sv
// Shared constants, types and field helpers for the peripheral reset and clock gate block
package prcg_pkg;

  // Bus widths and channel counts
  localparam int PRCG_ADDR_W = 8;
  localparam int PRCG_DATA_W = 32;
  localparam int PRCG_N_RST = 5;
  localparam int PRCG_N_CLK = 6;

  // Register byte offsets
  localparam logic [7:0] PRCG_OFS_RST_REQ = 8'h44;
  localparam logic [7:0] PRCG_OFS_CLK_GATE = 8'h48;
  localparam logic [7:0] PRCG_OFS_BLOCKED = 8'h80;

  // Reset-request field positions: audio, autocal, cipher, pulse train, two-wire 2
  localparam int PRCG_RST_POS [PRCG_N_RST] = '{23, 14, 10, 1, 0};
  // Clock-gate field positions: audio, cipher key, cipher, can, watchdog, rng
  localparam int PRCG_CLK_POS [PRCG_N_CLK] = '{23, 16, 15, 11, 4, 2};

  // Values after reset
  localparam logic [31:0] PRCG_RST_REQ_RESET = 32'h0000_0000;
  localparam logic [31:0] PRCG_CLK_GATE_RESET = 32'hffff_ffff;
  localparam logic [5:0] PRCG_CLK_DIS_RESET = 6'h3f;
  localparam logic [5:0] PRCG_BLOCKED_RESET = 6'h00;

  // Peripheral reset pulse length, rounded up to whole clock cycles
  localparam int PRCG_CLK_MHZ = 200;
  localparam int PRCG_PRST_TIME_NS = 40;
  localparam int PRCG_PRST_CYC_INT = (PRCG_PRST_TIME_NS * PRCG_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PRCG_PRST_CYCLES = 4'(PRCG_PRST_CYC_INT);
  localparam logic [3:0] PRCG_CNT_ZERO = 4'h0;
  localparam logic [3:0] PRCG_CNT_ONE = 4'h1;

  // Per-channel reset sequence states
  typedef enum logic [1:0] {
    PRCG_SEQ_IDLE,
    PRCG_SEQ_HOLD,
    PRCG_SEQ_RELEASE
  } prcg_seq_t;

  // Gather the reset-request fields out of a bus word
  function automatic logic [PRCG_N_RST-1:0] prcg_rst_pick(input logic [31:0] w);
    logic [PRCG_N_RST-1:0] v;
    v = '0;
    for (int i = 0; i < PRCG_N_RST; i++) begin
      v[i] = w[PRCG_RST_POS[i]];
    end
    return v;
  endfunction

  // Place reset-request fields into a word, reserved bits zero
  function automatic logic [31:0] prcg_rst_place(input logic [PRCG_N_RST-1:0] v);
    logic [31:0] w;
    w = PRCG_RST_REQ_RESET;
    for (int i = 0; i < PRCG_N_RST; i++) begin
      w[PRCG_RST_POS[i]] = v[i];
    end
    return w;
  endfunction

  // Gather the clock-gate fields out of a bus word
  function automatic logic [PRCG_N_CLK-1:0] prcg_clk_pick(input logic [31:0] w);
    logic [PRCG_N_CLK-1:0] v;
    v = '0;
    for (int i = 0; i < PRCG_N_CLK; i++) begin
      v[i] = w[PRCG_CLK_POS[i]];
    end
    return v;
  endfunction

  // Place clock-gate fields into a word, reserved bits one
  function automatic logic [31:0] prcg_clk_place(input logic [PRCG_N_CLK-1:0] v);
    logic [31:0] w;
    w = PRCG_CLK_GATE_RESET;
    for (int i = 0; i < PRCG_N_CLK; i++) begin
      w[PRCG_CLK_POS[i]] = v[i];
    end
    return w;
  endfunction

endpackage

// >>> rtl/prcg_rst_seq.sv
// Per-peripheral reset sequencers, one small state machine per channel
`timescale 1ns/1ps
module prcg_rst_seq
  import prcg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Start requests, one-cycle pulses
  input wire logic [prcg_pkg::PRCG_N_RST-1:0] start,
  // Channel status and reset drives
  output logic [prcg_pkg::PRCG_N_RST-1:0] busy,
  output logic [prcg_pkg::PRCG_N_RST-1:0] periph_rst
);
  import prcg_pkg::*;

  prcg_seq_t state_reg [PRCG_N_RST];
  logic [3:0] cnt_reg [PRCG_N_RST];

  // Reset held for the full count, then one release cycle before busy drops
  always_ff @(posedge clk) begin
    for (int i = 0; i < PRCG_N_RST; i++) begin
      if (sys_rst) begin
        state_reg[i] <= PRCG_SEQ_IDLE;
        cnt_reg[i] <= PRCG_CNT_ZERO;
      end else begin
        case (state_reg[i])
          PRCG_SEQ_IDLE: begin
            if (start[i]) begin
              state_reg[i] <= PRCG_SEQ_HOLD;
              cnt_reg[i] <= PRCG_PRST_CYCLES;
            end
          end
          PRCG_SEQ_HOLD: begin
            cnt_reg[i] <= cnt_reg[i] - PRCG_CNT_ONE;
            if (cnt_reg[i] == PRCG_CNT_ONE) begin
              state_reg[i] <= PRCG_SEQ_RELEASE;
            end
          end
          PRCG_SEQ_RELEASE: state_reg[i] <= PRCG_SEQ_IDLE;
          default: state_reg[i] <= PRCG_SEQ_IDLE;
        endcase
      end
    end
  end

  // Status and drive decode
  always_comb begin
    for (int i = 0; i < PRCG_N_RST; i++) begin
      busy[i] = (state_reg[i] != PRCG_SEQ_IDLE);
      periph_rst[i] = (state_reg[i] == PRCG_SEQ_HOLD);
    end
  end

endmodule

// >>> rtl/prcg_top.sv
// Peripheral reset request and clock gate control registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module prcg_top
  import prcg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [prcg_pkg::PRCG_ADDR_W-1:0] reg_addr,
  input wire logic [prcg_pkg::PRCG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [prcg_pkg::PRCG_DATA_W-1:0] reg_rdata,
  // Peripheral reset drives
  output logic audio_periph_rst,
  output logic autocal_periph_rst,
  output logic cipher_periph_rst,
  output logic pulse_train_periph_rst,
  output logic two_wire2_periph_rst,
  // Peripheral clock enables
  output logic audio_clk_en,
  output logic cipher_key_clk_en,
  output logic cipher_clk_en,
  output logic can_clk_en,
  output logic watchdog_clk_en,
  output logic rng_clk_en,
  // Peripheral register strobes, in from the bus decoder
  input wire logic [prcg_pkg::PRCG_N_CLK-1:0] pbus_wr_in,
  input wire logic [prcg_pkg::PRCG_N_CLK-1:0] pbus_rd_in,
  // Peripheral register strobes, out to the peripherals
  output logic [prcg_pkg::PRCG_N_CLK-1:0] pbus_wr_out,
  output logic [prcg_pkg::PRCG_N_CLK-1:0] pbus_rd_out
);
  import prcg_pkg::*;

  // Address decode
  wire hit_rst_req = (reg_addr == PRCG_OFS_RST_REQ);
  wire hit_clk_gate = (reg_addr == PRCG_OFS_CLK_GATE);
  wire hit_blocked = (reg_addr == PRCG_OFS_BLOCKED);

  // Write strobes per register
  wire wr_rst_req = reg_wr & hit_rst_req;
  wire wr_clk_gate = reg_wr & hit_clk_gate;
  wire wr_blocked = reg_wr & hit_blocked;

  // Fields carried by the write data
  wire [PRCG_N_RST-1:0] wr_rst_fields = prcg_rst_pick(reg_wdata);
  wire [PRCG_N_CLK-1:0] wr_clk_fields = prcg_clk_pick(reg_wdata);
  wire [PRCG_N_CLK-1:0] wr_blk_fields = reg_wdata[PRCG_N_CLK-1:0];

  // State held by this block
  logic [PRCG_N_CLK-1:0] clk_dis_reg;
  logic [PRCG_N_CLK-1:0] clk_dis_next;
  logic [PRCG_N_CLK-1:0] blocked_reg;
  logic [PRCG_N_CLK-1:0] blocked_next;
  logic [PRCG_DATA_W-1:0] rdata_reg;
  logic [PRCG_DATA_W-1:0] rdata_next;

  // Sequencer and gate connections
  logic [PRCG_N_RST-1:0] seq_busy;
  logic [PRCG_N_RST-1:0] seq_rst;
  logic [PRCG_N_RST-1:0] seq_start;
  logic [PRCG_N_CLK-1:0] gate_refused;

  // Only ones start a reset; a channel already busy ignores its bit,
  // so a second write can neither restart nor cut short a running reset
  assign seq_start = wr_rst_req ? (wr_rst_fields & ~seq_busy) : '0;

  // Reset sequencers; idle after system reset so nothing is pending
  prcg_rst_seq u_rst_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(seq_start),
    .busy(seq_busy),
    .periph_rst(seq_rst)
  );

  // Per-channel reset drives, field order fixed by the package
  assign audio_periph_rst = seq_rst[0];
  assign autocal_periph_rst = seq_rst[1];
  assign cipher_periph_rst = seq_rst[2];
  assign pulse_train_periph_rst = seq_rst[3];
  assign two_wire2_periph_rst = seq_rst[4];

  // Gate register: only documented fields take write data
  assign clk_dis_next = wr_clk_gate ? wr_clk_fields : clk_dis_reg;

  // Clock enables: one in the gate field stops the peripheral.
  // Enables, not gated clocks, keep the design on one clock tree;
  // a peripheral with its enable low holds every flop as it was.
  assign audio_clk_en = ~clk_dis_reg[0];
  assign cipher_key_clk_en = ~clk_dis_reg[1];
  assign cipher_clk_en = ~clk_dis_reg[2];
  assign can_clk_en = ~clk_dis_reg[3];
  assign watchdog_clk_en = ~clk_dis_reg[4];
  assign rng_clk_en = ~clk_dis_reg[5];

  // Register strobes to stopped peripherals are dropped here
  prcg_bus_gate u_bus_gate (
    .clk_dis(clk_dis_reg),
    .wr_in(pbus_wr_in),
    .rd_in(pbus_rd_in),
    .wr_out(pbus_wr_out),
    .rd_out(pbus_rd_out),
    .refused(gate_refused)
  );

  // Refused-access record: sticky, write one to clear, a new refusal
  // in the clearing cycle wins so no event is lost
  assign blocked_next = (blocked_reg & ~(wr_blocked ? wr_blk_fields : '0)) | gate_refused;

  // Read mux; reset request shows live busy, reserved bits fixed
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      if (hit_rst_req) begin
        rdata_next = prcg_rst_place(seq_busy);
      end else if (hit_clk_gate) begin
        rdata_next = prcg_clk_place(clk_dis_reg);
      end else if (hit_blocked) begin
        rdata_next = {{(PRCG_DATA_W - PRCG_N_CLK){1'b0}}, blocked_reg};
      end else begin
        rdata_next = '0;
      end
    end
  end

  // Gate register: every peripheral clock stopped after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_dis_reg <= PRCG_CLK_DIS_RESET;
    end else begin
      clk_dis_reg <= clk_dis_next;
    end
  end

  // Refused-access record
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blocked_reg <= PRCG_BLOCKED_RESET;
    end else begin
      blocked_reg <= blocked_next;
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// >>> test/prcg_properties.sv
// Concurrent checks on the reset request and clock gate ports
`timescale 1ns/1ps
module prcg_properties
  import prcg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Reset drives and clock enables
  input wire logic audio_periph_rst,
  input wire logic pulse_train_periph_rst,
  input wire logic two_wire2_periph_rst,
  input wire logic audio_clk_en,
  input wire logic cipher_key_clk_en,
  input wire logic cipher_clk_en,
  input wire logic can_clk_en,
  input wire logic watchdog_clk_en,
  input wire logic rng_clk_en,
  // Peripheral strobes
  input wire logic [5:0] pbus_wr_in,
  input wire logic [5:0] pbus_rd_in,
  input wire logic [5:0] pbus_wr_out,
  input wire logic [5:0] pbus_rd_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Enables in strobe order, audio at bit 0
  wire [5:0] en = {rng_clk_en, watchdog_clk_en, can_clk_en, cipher_clk_en,
    cipher_key_clk_en, audio_clk_en};
  // Back-to-back write excluded: channel may already be busy
  property p_wr2;
    reg_wr && reg_addr == 8'h44 && reg_wdata[0] && !two_wire2_periph_rst
      && !$past(two_wire2_periph_rst) && !$past(reg_wr)
      |=> two_wire2_periph_rst[*8] ##1 !two_wire2_periph_rst;
  endproperty
  a_wr2: assert property (p_wr2) else $error("two-wire reset pulse wrong");
  property p_start;
    $rose(audio_periph_rst) |-> $past(reg_wr && reg_addr == 8'h44 && reg_wdata[23]);
  endproperty
  a_start: assert property (p_start) else $error("audio reset without request");
  property p_hold;
    $rose(pulse_train_periph_rst) |-> pulse_train_periph_rst[*8] ##1 !pulse_train_periph_rst;
  endproperty
  a_hold: assert property (p_hold) else $error("pulse train reset length");
  property p_clk;
    reg_wr && reg_addr == 8'h48 |=> can_clk_en == !$past(reg_wdata[11]);
  endproperty
  a_clk: assert property (p_clk) else $error("can enable not from gate bit");
  property p_wgate;
    pbus_wr_out == (pbus_wr_in & en);
  endproperty
  a_wgate: assert property (p_wgate) else $error("write strobe not gated");
  property p_rgate;
    pbus_rd_out == (pbus_rd_in & en);
  endproperty
  a_rgate: assert property (p_rgate) else $error("read strobe not gated");
  property p_keep;
    !$stable(watchdog_clk_en) |-> $past(reg_wr && reg_addr == 8'h48);
  endproperty
  a_keep: assert property (p_keep) else $error("watchdog enable moved alone");
  property p_rdg;
    reg_rd && reg_addr == 8'h48 |=> reg_rdata[31:24] == 8'hff
      && reg_rdata[23] == !audio_clk_en && reg_rdata[2] == !rng_clk_en;
  endproperty
  a_rdg: assert property (p_rdg) else $error("gate read wrong");
  property p_rdr;
    reg_rd && reg_addr == 8'h44 |=> reg_rdata[31:24] == 8'h00 && reg_rdata[9:2] == 8'h00
      && (reg_rdata[0] || !$past(two_wire2_periph_rst));
  endproperty
  a_rdr: assert property (p_rdr) else $error("reset request read wrong");
  // Main scenarios
  c_wr2: cover property (reg_wr && reg_addr == 8'h44 && reg_wdata[0]);
  c_end: cover property ($fell(pulse_train_periph_rst));
  c_ref: cover property (pbus_rd_in[3] && !pbus_rd_out[3]);
endmodule
bind prcg_top prcg_properties u_props (.*);

// >>> test/prcg_top_bench.sv
// Self-checking bench for the reset request and clock gate block
`timescale 1ns/1ps
module prcg_top_bench;
  import prcg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] pbus_wr_in = 6'h00;
  logic [5:0] pbus_rd_in = 6'h00;
  wire [31:0] reg_rdata;
  wire [5:0] pbus_wr_out;
  wire [5:0] pbus_rd_out;
  wire [5:0] en;
  wire [4:0] prst;
  int bad_count = 0;
  int cmp_count = 0;
  int n = 0;
  prcg_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .audio_periph_rst(prst[4]),
    .autocal_periph_rst(prst[3]), .cipher_periph_rst(prst[2]),
    .pulse_train_periph_rst(prst[1]), .two_wire2_periph_rst(prst[0]),
    .audio_clk_en(en[0]), .cipher_key_clk_en(en[1]), .cipher_clk_en(en[2]),
    .can_clk_en(en[3]), .watchdog_clk_en(en[4]), .rng_clk_en(en[5]),
    .pbus_wr_in(pbus_wr_in), .pbus_rd_in(pbus_rd_in), .pbus_wr_out(pbus_wr_out),
    .pbus_rd_out(pbus_rd_out));
  always #2.5 clk = ~clk;
  // Counts cycles the two-wire reset is driven
  always @(posedge clk) if (prst[0] === 1'b1) n++;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_reset;
    rd(8'h48, 32'hffffffff);
    rd(8'h44, 32'h0);
    chk("clk_en", {26'h0, en}, 32'h0);
    $display("reset values done");
  endtask
  task t_gate;
    wr(8'h48, 32'h0);
    rd(8'h48, 32'hff7e77eb);
    chk("clk_en", {26'h0, en}, 32'h3f);
    wr(8'h48, 32'h0000_0800);
    rd(8'h48, 32'hff7e7feb);
    @(posedge clk);
    pbus_wr_in <= 6'h3f;
    pbus_rd_in <= 6'h3f;
    #1 chk("rd_out", {26'h0, pbus_rd_out}, 32'h37);
    chk("wr_out", {26'h0, pbus_wr_out}, 32'h37);
    @(posedge clk);
    pbus_wr_in <= 6'h00;
    pbus_rd_in <= 6'h00;
    rd(8'h4c, 32'h0);
    // Refusal record: can strobes above were dropped, write one clears it
    rd(8'h80, 32'h0000_0008);
    wr(8'h80, 32'h0000_0008);
    rd(8'h80, 32'h0);
    $display("clock gate done");
  endtask
  // Zero and repeated one while busy must neither cancel nor restart
  task t_rst;
    n = 0;
    wr(8'h44, 32'h0080_4403);
    wr(8'h44, 32'h0);
    wr(8'h44, 32'h1);
    rd(8'h44, 32'h0080_4403);
    chk("prst", {27'h0, prst}, 32'h1f);
    repeat (12) @(posedge clk);
    rd(8'h44, 32'h0);
    chk("pulse", n, 32'd8);
    wr(8'h44, 32'hff00_0000);
    rd(8'h44, 32'h0);
    chk("prst", {27'h0, prst}, 32'h0);
    $display("reset requests done");
  endtask
  // System reset in mid-pulse leaves nothing pending, every clock stopped
  task t_sysrst;
    wr(8'h44, 32'h0000_4000);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h44, 32'h0);
    rd(8'h48, 32'hffffffff);
    chk("prst", {27'h0, prst}, 32'h0);
    chk("clk_en", {26'h0, en}, 32'h0);
    $display("system reset done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_gate;
    t_rst;
    t_sysrst;
    conclude;
  end
  // Hang guard
  initial begin
    #100us;
    bad_count++;
    conclude;
  end
endmodule
